// ===== dofu_regs.svh
// Register selects, operation classes and field positions for the operand formatter
// Included by the package and the formatter; definitions only
`ifndef DOFU_REGS_SVH
`define DOFU_REGS_SVH
`define DOFU_SEL_ACC0     4'h0
`define DOFU_SEL_ACC1     4'h1
`define DOFU_SEL_GRD0     4'h2
`define DOFU_SEL_GRD1     4'h3
`define DOFU_SEL_X0       4'h4
`define DOFU_SEL_X1       4'h5
`define DOFU_SEL_Y0       4'h6
`define DOFU_SEL_Y1       4'h7
`define DOFU_SEL_M0       4'h8
`define DOFU_SEL_M1       4'h9
`define DOFU_OP_FIXED     3'h0
`define DOFU_OP_INTEGER   3'h1
`define DOFU_OP_LOGIC     3'h2
`define DOFU_OP_LOD       3'h3
`define DOFU_OP_ASHIFT    3'h4
`define DOFU_OP_LSHIFT    3'h5
`define DOFU_OP_SMUL      3'h6
`define DOFU_XF_XWORD     3'h0
`define DOFU_XF_YWORD     3'h1
`define DOFU_XF_SWORD     3'h2
`define DOFU_XF_SLONG     3'h3
`define DOFU_GUARD_W      8
`define DOFU_HALF_W       16
`define DOFU_ZERO16       16'h0000
`define DOFU_ZERO8        8'h00
`endif

// ===== dofu_pkg.sv
// Types shared by the operand formatter
// Assumes dofu_regs.svh for select and class codes
`include "dofu_regs.svh"
package dofu_pkg;
  typedef logic [3:0]  dofu_sel_t;
  typedef logic [39:0] dofu_wide_t;
  // Datapath operation request and result
  typedef struct packed {
    logic      valid;
    logic [2:0] op;
    dofu_sel_t src_a;
    dofu_sel_t src_b;
    dofu_sel_t dst;
    dofu_wide_t result;
  } dofu_alu_req_s;
  // Data transfer request
  typedef struct packed {
    logic       valid;
    logic [2:0] kind;
    logic       load;
    dofu_sel_t  sel;
    logic [31:0] wdata;
  } dofu_xfer_req_s;
  typedef enum logic [1:0] {
    DOFU_IDLE = 2'b00,
    DOFU_BUSY = 2'b01
  } dofu_state_e;
  // Registered state of the formatter
  typedef struct packed {
    logic [7:0]  grd0;
    logic [31:0] acc0;
    logic [7:0]  grd1;
    logic [31:0] acc1;
    logic [31:0] x0;
    logic [31:0] x1;
    logic [31:0] y0;
    logic [31:0] y1;
    logic [31:0] m0;
    logic [31:0] m1;
    dofu_wide_t  opnd_a;
    dofu_wide_t  opnd_b;
    logic        opnd_ok;
    logic [15:0] xbus_out;
    logic [15:0] ybus_out;
    logic [31:0] idb_out;
    logic        rd_valid;
    logic        illegal;
  } dofu_state_s;
endpackage

// ===== dofu_format_unit.sv
// Operand formatting register file for the signal-processing unit
// Assumes a decoder presents one request per cycle on each port, same clock
//
// Overview of operation
// - Accumulator source feeds stored guard bits
// - Input or multiplier source sign-extends guard
// - Accumulator destination takes full 40 bits
// - Input and multiplier destinations drop result bits 32-39; guard destinations keep bits 0-7
// - Integer sources ignore lower sixteen bits
// - Integer results zero destination lower half
// - Logical sources use bits 16-31 only
// - Logical results zero accumulator low, guard
// - X/Y word moves use upper half
// - Any register reachable on instruction data bus
// - Single word moves upper half only, except guard registers
// - Single longword moves full 32 bits, except guard registers
// - Guard registers transfer as eight-bit registers
// - Guard store sign-extends upper bits
// - Guard load keeps accumulator body
// - Signed multiply rejects accumulator zero source
`timescale 1ns/1ps
`include "dofu_regs.svh"
module dofu_format_unit (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  // Datapath requests
  input  wire dofu_pkg::dofu_alu_req_s  alu_req,
  input  wire dofu_pkg::dofu_xfer_req_s xfer_req,
  // Formatted operands
  output logic [39:0]                 opnd_a,
  output logic [39:0]                 opnd_b,
  output logic                        opnd_ok,
  output logic                        op_illegal,
  // Memory buses
  output logic [15:0]                 x_bus_out,
  output logic [15:0]                 y_bus_out,
  output logic [31:0]                 idb_out,
  output logic                        rd_valid
);
  dofu_pkg::dofu_state_s st_reg;
  dofu_pkg::dofu_state_s st_next;

  // Raw 40-bit view of a register
  function automatic logic [39:0] raw40(input dofu_pkg::dofu_state_s s, input logic [3:0] sel);
    case (sel)
      `DOFU_SEL_ACC0: raw40 = {s.grd0, s.acc0};
      `DOFU_SEL_ACC1: raw40 = {s.grd1, s.acc1};
      `DOFU_SEL_X0:   raw40 = {{`DOFU_GUARD_W{s.x0[31]}}, s.x0};
      `DOFU_SEL_X1:   raw40 = {{`DOFU_GUARD_W{s.x1[31]}}, s.x1};
      `DOFU_SEL_Y0:   raw40 = {{`DOFU_GUARD_W{s.y0[31]}}, s.y0};
      `DOFU_SEL_Y1:   raw40 = {{`DOFU_GUARD_W{s.y1[31]}}, s.y1};
      `DOFU_SEL_M0:   raw40 = {{`DOFU_GUARD_W{s.m0[31]}}, s.m0};
      `DOFU_SEL_M1:   raw40 = {{`DOFU_GUARD_W{s.m1[31]}}, s.m1};
      default:        raw40 = 40'h00_0000_0000;
    endcase
  endfunction

  // True for either accumulator body
  function automatic logic is_acc(input logic [3:0] sel);
    is_acc = (sel == `DOFU_SEL_ACC0) || (sel == `DOFU_SEL_ACC1);
  endfunction

  // Source formatting by operation class
  function automatic logic [39:0] fmt_src(input dofu_pkg::dofu_state_s s, input logic [3:0] sel,
                                          input logic [2:0] op);
    logic [39:0] r;
    r = raw40(s, sel);
    case (op)
      `DOFU_OP_FIXED, `DOFU_OP_LOD, `DOFU_OP_ASHIFT: fmt_src = r;
      `DOFU_OP_INTEGER: fmt_src = {r[39:16], `DOFU_ZERO16};
      `DOFU_OP_LOGIC, `DOFU_OP_LSHIFT, `DOFU_OP_SMUL:
        fmt_src = {`DOFU_ZERO8, r[31:16], `DOFU_ZERO16};
      default: fmt_src = r;
    endcase
  endfunction

  // Write a formatted value into the register file copy
  function automatic dofu_pkg::dofu_state_s put(input dofu_pkg::dofu_state_s s, input logic [3:0] sel,
                                                input logic [39:0] v);
    dofu_pkg::dofu_state_s t;
    t = s;
    case (sel)
      `DOFU_SEL_ACC0: {t.grd0, t.acc0} = v;
      `DOFU_SEL_ACC1: {t.grd1, t.acc1} = v;
      `DOFU_SEL_GRD0: t.grd0 = v[7:0];
      `DOFU_SEL_GRD1: t.grd1 = v[7:0];
      `DOFU_SEL_X0:   t.x0 = v[31:0];
      `DOFU_SEL_X1:   t.x1 = v[31:0];
      `DOFU_SEL_Y0:   t.y0 = v[31:0];
      `DOFU_SEL_Y1:   t.y1 = v[31:0];
      `DOFU_SEL_M0:   t.m0 = v[31:0];
      `DOFU_SEL_M1:   t.m1 = v[31:0];
      default:        t = s;
    endcase
    put = t;
  endfunction

  // Next-state logic
  always_comb begin
    logic [39:0] res;
    logic [39:0] rd;
    logic [39:0] ld;
    logic        bad;
    res = 40'h00_0000_0000;
    rd  = 40'h00_0000_0000;
    ld  = 40'h00_0000_0000;
    bad = 1'b0;
    st_next = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.opnd_ok  = 1'b0;
    st_next.illegal  = 1'b0;
    // Datapath operand and result formatting
    if (alu_req.valid) begin
      bad = (alu_req.op == `DOFU_OP_SMUL) &&
            ((alu_req.src_a == `DOFU_SEL_ACC0) || (alu_req.src_b == `DOFU_SEL_ACC0));
      st_next.illegal = bad;
      st_next.opnd_ok = !bad;
      st_next.opnd_a  = fmt_src(st_reg, alu_req.src_a, alu_req.op);
      st_next.opnd_b  = fmt_src(st_reg, alu_req.src_b, alu_req.op);
      res = alu_req.result;
      case (alu_req.op)
        `DOFU_OP_INTEGER, `DOFU_OP_LOD: res = {res[39:16], `DOFU_ZERO16};
        `DOFU_OP_LOGIC, `DOFU_OP_LSHIFT: res = {`DOFU_ZERO8, res[31:16], `DOFU_ZERO16};
        default: res = alu_req.result;
      endcase
      if (!bad) begin
        st_next = put(st_next, alu_req.dst, res);
      end
    end
    // Memory transfers
    // Applied after the datapath write, so a same-cycle write to one register ends with the transfer
    // Store data is taken from the registered copy, never from this cycle's datapath result
    if (xfer_req.valid) begin
      rd = raw40(st_reg, xfer_req.sel);
      case (xfer_req.sel)
        `DOFU_SEL_GRD0: rd = {{32{st_reg.grd0[7]}}, st_reg.grd0};
        `DOFU_SEL_GRD1: rd = {{32{st_reg.grd1[7]}}, st_reg.grd1};
        default: rd = raw40(st_reg, xfer_req.sel);
      endcase
      case (xfer_req.kind)
        `DOFU_XF_XWORD: begin
          st_next.xbus_out = rd[31:16];
          ld = {{24{xfer_req.wdata[15]}}, xfer_req.wdata[15:0]} << `DOFU_HALF_W;
        end
        `DOFU_XF_YWORD: begin
          st_next.ybus_out = rd[31:16];
          ld = {{24{xfer_req.wdata[15]}}, xfer_req.wdata[15:0]} << `DOFU_HALF_W;
        end
        `DOFU_XF_SWORD: begin
          st_next.idb_out = (xfer_req.sel == `DOFU_SEL_GRD0 || xfer_req.sel == `DOFU_SEL_GRD1) ?
                            rd[31:0] : {rd[31:16], `DOFU_ZERO16};
          ld = {{24{xfer_req.wdata[15]}}, xfer_req.wdata[15:0]} << `DOFU_HALF_W;
        end
        default: begin
          st_next.idb_out = rd[31:0];
          ld = {{`DOFU_GUARD_W{xfer_req.wdata[31]}}, xfer_req.wdata};
        end
      endcase
      if (xfer_req.sel == `DOFU_SEL_GRD0 || xfer_req.sel == `DOFU_SEL_GRD1) begin
        ld = {32'h0000_0000, xfer_req.wdata[7:0]};
      end
      if (xfer_req.load) begin
        if (!is_acc(xfer_req.sel)) begin
          ld[39:32] = `DOFU_ZERO8;
        end
        st_next = put(st_next, xfer_req.sel, ld);
      end else begin
        st_next.rd_valid = 1'b1;
      end
    end
    // Reset last, so it overrides any request seen in the same cycle
    if (srst) begin
      st_next = '0;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    st_reg <= st_next;
  end

  assign opnd_a     = st_reg.opnd_a;
  assign opnd_b     = st_reg.opnd_b;
  assign opnd_ok    = st_reg.opnd_ok;
  assign op_illegal = st_reg.illegal;
  assign x_bus_out  = st_reg.xbus_out;
  assign y_bus_out  = st_reg.ybus_out;
  assign idb_out    = st_reg.idb_out;
  assign rd_valid   = st_reg.rd_valid;

  // Checks
  // Each check looks one cycle after the taking edge, against the registered copy as it stood then

  // Fixed-point sources
  chk_acc_guard_src: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_FIXED && alu_req.src_a == `DOFU_SEL_ACC1
    |=> opnd_a[39:32] == $past(st_reg.grd1))
    else $error("guard bits not fed");
  chk_acc0_guard_src: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_FIXED && alu_req.src_b == `DOFU_SEL_ACC0
    |=> opnd_b == {$past(st_reg.grd0), $past(st_reg.acc0)})
    else $error("acc zero operand wrong");
  chk_sign_ext_src: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_FIXED && alu_req.src_b == `DOFU_SEL_X0
    |=> opnd_b[39:32] == {`DOFU_GUARD_W{opnd_b[31]}})
    else $error("input not sign extended");
  chk_mreg_sign_src: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_ASHIFT && alu_req.src_a == `DOFU_SEL_M1
    |=> opnd_a == {{`DOFU_GUARD_W{$past(st_reg.m1[31])}}, $past(st_reg.m1)})
    else $error("multiplier not sign extended");

  // Fixed-point destinations
  chk_acc_dest_full: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_FIXED && alu_req.dst == `DOFU_SEL_ACC0 && !xfer_req.valid
    |=> {st_reg.grd0, st_reg.acc0} == $past(alu_req.result))
    else $error("acc not written");
  chk_acc1_dest_full: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_ASHIFT && alu_req.dst == `DOFU_SEL_ACC1 && !xfer_req.valid
    |=> {st_reg.grd1, st_reg.acc1} == $past(alu_req.result))
    else $error("acc one not written");
  chk_reg_dest_low: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_FIXED && alu_req.dst == `DOFU_SEL_X0 && !xfer_req.valid
    |=> st_reg.x0 == $past(alu_req.result[31:0]))
    else $error("input reg not written");

  // Integer format
  chk_int_low_zero: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_INTEGER
    |=> opnd_a[15:0] == `DOFU_ZERO16)
    else $error("integer low half used");
  chk_int_src_high: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_INTEGER && alu_req.src_b == `DOFU_SEL_Y0
    |=> opnd_b[39:16] == {{`DOFU_GUARD_W{$past(st_reg.y0[31])}}, $past(st_reg.y0[31:16])})
    else $error("integer source high wrong");
  chk_int_dest_zero: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_INTEGER && alu_req.dst == `DOFU_SEL_Y1 && !xfer_req.valid
    |=> st_reg.y1 == {$past(alu_req.result[31:16]), `DOFU_ZERO16})
    else $error("integer low half kept");

  // Logical format
  chk_logic_src: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_LOGIC
    |=> opnd_a[39:32] == `DOFU_ZERO8 && opnd_a[15:0] == `DOFU_ZERO16)
    else $error("logic source not masked");
  chk_logic_src_b: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_LOGIC && alu_req.src_b == `DOFU_SEL_ACC0
    |=> opnd_b == {`DOFU_ZERO8, $past(st_reg.acc0[31:16]), `DOFU_ZERO16})
    else $error("logic acc source wrong");
  chk_logic_dest: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_LOGIC && alu_req.dst == `DOFU_SEL_ACC1 && !xfer_req.valid
    |=> st_reg.grd1 == `DOFU_ZERO8 && st_reg.acc1[15:0] == `DOFU_ZERO16)
    else $error("logic dest not cleared");
  chk_logic_dest_val: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_LSHIFT && alu_req.dst == `DOFU_SEL_ACC0 && !xfer_req.valid
    |=> st_reg.acc0[31:16] == $past(alu_req.result[31:16]) && st_reg.grd0 == `DOFU_ZERO8)
    else $error("logic result not written");

  // X and Y word moves
  chk_xword_store: assert property (@(posedge sys_clk) disable iff (srst)
    xfer_req.valid && !xfer_req.load && xfer_req.kind == `DOFU_XF_XWORD && xfer_req.sel == `DOFU_SEL_X1
    |=> x_bus_out == $past(st_reg.x1[31:16]))
    else $error("x bus store wrong");
  chk_yword_load: assert property (@(posedge sys_clk) disable iff (srst)
    xfer_req.valid && xfer_req.load && xfer_req.kind == `DOFU_XF_YWORD && xfer_req.sel == `DOFU_SEL_Y0 && !alu_req.valid
    |=> st_reg.y0 == {$past(xfer_req.wdata[15:0]), `DOFU_ZERO16})
    else $error("y bus load wrong");

  // Store strobe on every store, and only then
  chk_store_pulse: assert property (@(posedge sys_clk) disable iff (srst)
    xfer_req.valid && !xfer_req.load
    |=> rd_valid)
    else $error("store strobe missing");
  chk_no_store_pulse: assert property (@(posedge sys_clk) disable iff (srst)
    !(xfer_req.valid && !xfer_req.load)
    |=> !rd_valid)
    else $error("spurious store strobe");

  // Single word and longword moves
  chk_sword_store: assert property (@(posedge sys_clk) disable iff (srst)
    xfer_req.valid && !xfer_req.load && xfer_req.kind == `DOFU_XF_SWORD && xfer_req.sel == `DOFU_SEL_M0
    |=> idb_out == {$past(st_reg.m0[31:16]), `DOFU_ZERO16})
    else $error("word store wrong");
  chk_sword_load: assert property (@(posedge sys_clk) disable iff (srst)
    xfer_req.valid && xfer_req.load && xfer_req.kind == `DOFU_XF_SWORD && xfer_req.sel == `DOFU_SEL_X0 && !alu_req.valid
    |=> st_reg.x0 == {$past(xfer_req.wdata[15:0]), `DOFU_ZERO16})
    else $error("word load wrong");
  chk_slong_store: assert property (@(posedge sys_clk) disable iff (srst)
    xfer_req.valid && !xfer_req.load && xfer_req.kind == `DOFU_XF_SLONG && xfer_req.sel == `DOFU_SEL_Y1
    |=> idb_out == $past(st_reg.y1))
    else $error("longword store wrong");
  chk_slong_load: assert property (@(posedge sys_clk) disable iff (srst)
    xfer_req.valid && xfer_req.load && xfer_req.kind == `DOFU_XF_SLONG && xfer_req.sel == `DOFU_SEL_M1 && !alu_req.valid
    |=> st_reg.m1 == $past(xfer_req.wdata))
    else $error("longword load wrong");

  // Guard registers as eight-bit registers
  chk_guard_word_ld: assert property (@(posedge sys_clk) disable iff (srst)
    xfer_req.valid && xfer_req.load && xfer_req.kind == `DOFU_XF_SWORD && xfer_req.sel == `DOFU_SEL_GRD1 && !alu_req.valid
    |=> st_reg.grd1 == $past(xfer_req.wdata[7:0]) && st_reg.acc1 == $past(st_reg.acc1))
    else $error("guard word load wrong");
  chk_guard_store: assert property (@(posedge sys_clk) disable iff (srst)
    xfer_req.valid && !xfer_req.load && xfer_req.sel == `DOFU_SEL_GRD1 && xfer_req.kind == `DOFU_XF_SLONG
    |=> rd_valid && idb_out == {{24{idb_out[7]}}, $past(st_reg.grd1)})
    else $error("guard store not extended");
  chk_guard_wstore: assert property (@(posedge sys_clk) disable iff (srst)
    xfer_req.valid && !xfer_req.load && xfer_req.sel == `DOFU_SEL_GRD0 && xfer_req.kind == `DOFU_XF_SWORD
    |=> idb_out == {{24{$past(st_reg.grd0[7])}}, $past(st_reg.grd0)})
    else $error("guard word store wrong");
  chk_guard_load: assert property (@(posedge sys_clk) disable iff (srst)
    xfer_req.valid && xfer_req.load && xfer_req.sel == `DOFU_SEL_GRD0 && !alu_req.valid
    |=> st_reg.acc0 == $past(st_reg.acc0) && st_reg.grd0 == $past(xfer_req.wdata[7:0]))
    else $error("guard load disturbed body");

  // Signed multiply source limits
  chk_smul_reject: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_SMUL && alu_req.src_a == `DOFU_SEL_ACC0
    |=> op_illegal && !opnd_ok)
    else $error("acc zero accepted by multiply");
  chk_smul_src_b: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_SMUL && alu_req.src_b == `DOFU_SEL_ACC0
    |=> op_illegal && !opnd_ok)
    else $error("acc zero accepted as second source");
  chk_smul_no_write: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_SMUL && alu_req.src_a == `DOFU_SEL_ACC0 && alu_req.dst == `DOFU_SEL_ACC1
    && !xfer_req.valid |=> st_reg.acc1 == $past(st_reg.acc1) && st_reg.grd1 == $past(st_reg.grd1))
    else $error("refused multiply wrote result");
  chk_ok_legal: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op != `DOFU_OP_SMUL
    |=> opnd_ok && !op_illegal)
    else $error("legal operation refused");

  // Shift and detect classes
  chk_lshift_src: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_LSHIFT
    |=> opnd_a[39:32] == `DOFU_ZERO8 && opnd_a[15:0] == `DOFU_ZERO16)
    else $error("logical shift not masked");
  chk_lod_src: assert property (@(posedge sys_clk) disable iff (srst)
    alu_req.valid && alu_req.op == `DOFU_OP_LOD && alu_req.src_a == `DOFU_SEL_ACC1
    |=> opnd_a == {$past(st_reg.grd1), $past(st_reg.acc1)})
    else $error("detect source not fixed format");

  // Accumulator loads over the instruction data bus
  chk_acc_word_load: assert property (@(posedge sys_clk) disable iff (srst)
    xfer_req.valid && xfer_req.load && xfer_req.kind == `DOFU_XF_SWORD && xfer_req.sel == `DOFU_SEL_ACC1 && !alu_req.valid
    |=> st_reg.acc1 == {$past(xfer_req.wdata[15:0]), `DOFU_ZERO16}
        && st_reg.grd1 == {`DOFU_GUARD_W{$past(xfer_req.wdata[15])}})
    else $error("acc word load wrong");
  chk_acc_long_load: assert property (@(posedge sys_clk) disable iff (srst)
    xfer_req.valid && xfer_req.load && xfer_req.kind == `DOFU_XF_SLONG && xfer_req.sel == `DOFU_SEL_ACC0 && !alu_req.valid
    |=> {st_reg.grd0, st_reg.acc0} == {{`DOFU_GUARD_W{$past(xfer_req.wdata[31])}}, $past(xfer_req.wdata)})
    else $error("acc longword load wrong");
endmodule // dofu_format_unit

// ===== dofu_mem_model.sv
// Far-side memory model: keeps the last word stored on each bus
// Assumes rd_valid marks one cycle of store data on the bus outputs
`timescale 1ns/1ps
module dofu_mem_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Store buses from the unit
  input  wire logic        rd_valid,
  input  wire logic [15:0] x_bus_out,
  input  wire logic [15:0] y_bus_out,
  input  wire logic [31:0] idb_out,
  // Captured memory words
  output logic      [15:0] x_mem,
  output logic      [15:0] y_mem,
  output logic      [31:0] idb_mem,
  output logic      [7:0]  n_store
);
  // Memory write on each store pulse
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      x_mem   <= 16'h0000;
      y_mem   <= 16'h0000;
      idb_mem <= 32'h00000000;
      n_store <= 8'h00;
    end else if (rd_valid) begin
      x_mem   <= x_bus_out;
      y_mem   <= y_bus_out;
      idb_mem <= idb_out;
      n_store <= n_store + 8'h01;
    end
  end
endmodule // dofu_mem_model

// ===== test_dsp_operand_format_unit.sv
// Self-checking bench for the operand formatter and its memory model
// Assumes one-cycle answers and the select codes of dofu_regs.svh
`timescale 1ns/1ps
`include "dofu_regs.svh"
module test_dsp_operand_format_unit;
  logic                    sys_clk, srst, opnd_ok, op_illegal, rd_valid;
  dofu_pkg::dofu_alu_req_s  alu_req;
  dofu_pkg::dofu_xfer_req_s xfer_req;
  logic [39:0]             opnd_a, opnd_b;
  logic [15:0]             x_bus_out, y_bus_out, x_mem, y_mem;
  logic [31:0]             idb_out, idb_mem;
  logic [7:0]              n_store;
  int                      n_errors, cmp_count;
  dofu_format_unit i_dofu_format_unit (.sys_clk(sys_clk), .srst(srst), .alu_req(alu_req), .xfer_req(xfer_req),
    .opnd_a(opnd_a), .opnd_b(opnd_b), .opnd_ok(opnd_ok), .op_illegal(op_illegal), .x_bus_out(x_bus_out),
    .y_bus_out(y_bus_out), .idb_out(idb_out), .rd_valid(rd_valid));
  dofu_mem_model i_dofu_mem_model (.sys_clk(sys_clk), .srst(srst), .rd_valid(rd_valid), .x_bus_out(x_bus_out),
    .y_bus_out(y_bus_out), .idb_out(idb_out), .x_mem(x_mem), .y_mem(y_mem), .idb_mem(idb_mem), .n_store(n_store));
  // Clock at 40 MHz
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Value compare
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One datapath request, returns after the answer lands
  task automatic alu(input logic [2:0] op, input logic [3:0] a, b, d, input logic [39:0] r);
    @(posedge sys_clk) alu_req <= '{1'b1, op, a, b, d, r};
    @(posedge sys_clk) alu_req.valid <= 1'b0;
    #1;
  endtask
  // One transfer request
  task automatic xfer(input logic [2:0] k, input logic ld, input logic [3:0] s, input logic [31:0] w);
    @(posedge sys_clk) xfer_req <= '{1'b1, k, ld, s, w};
    @(posedge sys_clk) xfer_req.valid <= 1'b0;
    #1;
  endtask
  // Store and wait for the model to take it
  task automatic st(input logic [2:0] k, input logic [3:0] s);
    logic [7:0] n;
    n = n_store;
    xfer(k, 1'b0, s, 32'h00000000);
    @(posedge sys_clk);
    #1;
    chk({32'h0, n_store}, {32'h0, n + 8'h01});
  endtask
  // Verdict
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial begin
    n_errors = 0;
    cmp_count = 0;
    srst = 1'b1;
    alu_req = '0;
    xfer_req = '0;
    repeat (20) @(posedge sys_clk);
    #1;
    chk(opnd_a | {39'h0, opnd_ok}, 40'h0);
    chk({8'h0, idb_out}, 40'h0);
    srst <= 1'b0;
    $display("test reset done");
    // Fixed point sources and destinations
    xfer(`DOFU_XF_SLONG, 1'b1, `DOFU_SEL_ACC0, 32'h80001234);
    xfer(`DOFU_XF_SLONG, 1'b1, `DOFU_SEL_X0, 32'h80000000);
    alu(`DOFU_OP_FIXED, `DOFU_SEL_ACC0, `DOFU_SEL_X0, `DOFU_SEL_ACC1, 40'h123456789A);
    chk(opnd_a, 40'hFF80001234);
    chk(opnd_b, 40'hFF80000000);
    chk({39'h0, opnd_ok}, 40'h1);
    alu(`DOFU_OP_FIXED, `DOFU_SEL_ACC1, `DOFU_SEL_X1, `DOFU_SEL_X1, 40'h7F89ABCDEF);
    chk(opnd_a, 40'h123456789A);
    alu(`DOFU_OP_FIXED, `DOFU_SEL_X1, `DOFU_SEL_ACC1, `DOFU_SEL_M0, 40'h0);
    chk(opnd_a, 40'hFF89ABCDEF);
    $display("test fixed done");
    // Integer format
    alu(`DOFU_OP_INTEGER, `DOFU_SEL_ACC0, `DOFU_SEL_X1, `DOFU_SEL_X0, 40'h0012345678);
    chk(opnd_a, 40'hFF80000000);
    chk(opnd_b, 40'hFF89AB0000);
    st(`DOFU_XF_SLONG, `DOFU_SEL_X0);
    chk({8'h0, idb_mem}, 40'h0012340000);
    $display("test integer done");
    // Logical format
    alu(`DOFU_OP_LOGIC, `DOFU_SEL_ACC0, `DOFU_SEL_X0, `DOFU_SEL_ACC1, 40'hFFABCD1234);
    chk(opnd_a, 40'h0080000000);
    chk(opnd_b, 40'h0012340000);
    alu(`DOFU_OP_FIXED, `DOFU_SEL_ACC1, `DOFU_SEL_ACC1, `DOFU_SEL_M0, 40'h0);
    chk(opnd_a, 40'h00ABCD0000);
    $display("test logic done");
    // Shift and detect classes
    for (int i = 0; i < 3; i++) begin
      alu(3'(`DOFU_OP_LOD + i), `DOFU_SEL_ACC0, `DOFU_SEL_X0, `DOFU_SEL_M0, 40'h0);
      chk(opnd_a, (i == 2) ? 40'h0080000000 : 40'hFF80001234);
    end
    $display("test shift done");
    // X and Y word moves, single longword and single word stores
    xfer(`DOFU_XF_XWORD, 1'b1, `DOFU_SEL_Y1, 32'h0000BEEF);
    st(`DOFU_XF_XWORD, `DOFU_SEL_Y1);
    chk({24'h0, x_mem}, 40'h000000BEEF);
    st(`DOFU_XF_YWORD, `DOFU_SEL_Y1);
    chk({24'h0, y_mem}, 40'h000000BEEF);
    st(`DOFU_XF_SLONG, `DOFU_SEL_Y1);
    chk({8'h0, idb_mem}, 40'h00BEEF0000);
    st(`DOFU_XF_SWORD, `DOFU_SEL_Y1);
    chk({8'h0, idb_mem}, 40'h00BEEF0000);
    $display("test xy done");
    // Guard registers as separate eight-bit registers
    xfer(`DOFU_XF_SWORD, 1'b1, `DOFU_SEL_GRD1, 32'h12345681);
    alu(`DOFU_OP_FIXED, `DOFU_SEL_ACC1, `DOFU_SEL_ACC1, `DOFU_SEL_M0, 40'h0);
    chk(opnd_a, 40'h81ABCD0000);
    st(`DOFU_XF_SLONG, `DOFU_SEL_GRD1);
    chk({8'h0, idb_mem}, 40'h00FFFFFF81);
    st(`DOFU_XF_SWORD, `DOFU_SEL_GRD1);
    chk({8'h0, idb_mem}, 40'h00FFFFFF81);
    xfer(`DOFU_XF_SWORD, 1'b1, `DOFU_SEL_ACC0, 32'h00007654);
    alu(`DOFU_OP_FIXED, `DOFU_SEL_ACC0, `DOFU_SEL_ACC0, `DOFU_SEL_M0, 40'h0);
    chk(opnd_a, 40'h0076540000);
    $display("test guard done");
    // Signed multiply refuses accumulator zero
    alu(`DOFU_OP_SMUL, `DOFU_SEL_ACC0, `DOFU_SEL_X0, `DOFU_SEL_ACC1, 40'h0011112222);
    chk({39'h0, op_illegal}, 40'h1);
    alu(`DOFU_OP_SMUL, `DOFU_SEL_ACC1, `DOFU_SEL_X0, `DOFU_SEL_M0, 40'h0);
    chk({38'h0, op_illegal, opnd_ok}, 40'h1);
    chk(opnd_a, 40'h00ABCD0000);
    $display("test refuse done");
    // Every register except the guard registers through the instruction data bus
    for (int s = 0; s < 10; s++) begin
      if (s == 2 || s == 3) continue;
      xfer(`DOFU_XF_SLONG, 1'b1, 4'(s), 32'h5A000000 + 32'(s));
      st(`DOFU_XF_SLONG, 4'(s));
      chk({8'h0, idb_mem}, 40'h005A000000 + 40'(s));
    end
    $display("test regs done");
    end_of_test();
  end
  // Watchdog
  initial begin
    #20000;
    n_errors++;
    end_of_test();
  end
endmodule // test_dsp_operand_format_unit
